// ==== hdl/homing_params.svh ====
// named constants for the homing supervision block
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH
// =====================================================================
// register byte offsets
`define HS_OFF_CTRL 8'h00
`define HS_OFF_MAXSW 8'h04
`define HS_OFF_SWLEN 8'h08
`define HS_OFF_MAXZERO 8'h0c
`define HS_OFF_STATUS 8'h10
`define HS_OFF_REPORT 8'h14
// =====================================================================
// widths and field positions
`define HS_DIST_W 24
`define HS_ID_W 8
`define HS_CTRL_START 0
`define HS_CTRL_RESET 1
`define HS_CTRL_CHAN_LO 8
`define HS_CTRL_AXIS_LO 16
`define HS_REP_CHAN_LO 16
`define HS_REP_AXIS_LO 24
`define HS_ST_DIST_LO 8
// =====================================================================
// error codes (decimal, as reported)
`define HS_ERR_NONE 16'h0000
`define HS_ERR_NO_SWITCH 16'h4e20
`define HS_ERR_SWITCH_LOST 16'h4e21
`define HS_ERR_NO_ZERO 16'h4e22
// =====================================================================
// reset values of configuration
`define HS_RST_DIST 24'h000000
`define HS_RST_ID 8'h00
`endif

// ==== hdl/homing_pkg.sv ====
// types shared by the homing supervision modules
package homing_pkg;
    // =================================================================
    // homing phases, one-hot
    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_SEEK_SWITCH = 6'h02,
        PH_BRAKE = 6'h04,
        PH_LEAVE = 6'h08,
        PH_SEEK_ZERO = 6'h10,
        PH_FAULT = 6'h20
    } phase_e;
    typedef logic [23:0] dist_t;
endpackage : homing_pkg

// ==== hdl/dist_counter_if.sv ====
// carrier between the phase logic and one distance accumulator
`timescale 1ns/10ps
interface dist_counter_if;
    logic clear;
    logic step;
    homing_pkg::dist_t limit;
    homing_pkg::dist_t count;
    logic over;
    modport owner (output clear, output step, output limit, input count, input over);
    modport counter (input clear, input step, input limit, output count, output over);
endinterface : dist_counter_if

// ==== hdl/dist_counter.sv ====
// distance accumulator with limit compare
`timescale 1ns/10ps
`include "homing_params.svh"
module dist_counter (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    dist_counter_if.counter port
);
    homing_pkg::dist_t count_reg;
    homing_pkg::dist_t count_next;

    // =================================================================
    // accumulate increments, saturate so a long run never wraps to small
    always_comb begin
        count_next = count_reg;
        if (port.clear) begin
            count_next = `HS_RST_DIST;
        end else if (port.step && (count_reg != {`HS_DIST_W{1'b1}})) begin
            count_next = count_reg + 24'h000001;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= `HS_RST_DIST;
        end else if (ce) begin
            count_reg <= count_next;
        end
    end

    assign port.count = count_reg;
    assign port.over = (count_reg > port.limit);
endmodule : dist_counter

// ==== hdl/homing_supervision.sv ====
// homing supervision of one axis with apb register access
// What this block does
// - switch edge must come within max distance
// - switch lost before standstill raises error
// - zero marker missing within distance raises error
// - never accept a later zero marker
// - report carries channel and axis identifiers
// - errors latch until reset clears them
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "homing_params.svh"
module homing_supervision (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic referenceSwitch,
    input wire logic zeroMarker,
    input wire logic travelStep,
    input wire logic axisStandstill,
    output logic startDisable,
    output logic stopAxis,
    output logic homed
);
    // =================================================================
    // pin synchronisers; stage one feeds only stage two
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    logic [2:0] syncPrev_reg;
    logic [2:0] pins;
    assign pins = {travelStep, zeroMarker, referenceSwitch};

    always_ff @(posedge clock) begin
        if (rst) begin
            syncA_reg <= 3'h0;
            syncB_reg <= 3'h0;
            syncPrev_reg <= 3'h0;
        end else if (ce) begin
            syncA_reg <= pins;
            syncB_reg <= syncA_reg;
            syncPrev_reg <= syncB_reg;
        end
    end

    logic switchOn;
    logic switchRise;
    logic switchFall;
    logic markerRise;
    logic stepPulse;
    assign switchOn = syncB_reg[0];
    assign switchRise = syncB_reg[0] && !syncPrev_reg[0];
    assign switchFall = !syncB_reg[0] && syncPrev_reg[0];
    assign markerRise = syncB_reg[1] && !syncPrev_reg[1];
    assign stepPulse = syncB_reg[2] && !syncPrev_reg[2]; // one increment per rising edge

    // =================================================================
    // apb slave: answers in the first access cycle, no wait states
    logic writeHit;
    logic mapped;
    logic startCmd;
    logic resetCmd;
    assign writeHit = psel && penable && pwrite && pready;
    assign startCmd = writeHit && (paddr == `HS_OFF_CTRL) && pwdata[`HS_CTRL_START];
    assign resetCmd = writeHit && (paddr == `HS_OFF_CTRL) && pwdata[`HS_CTRL_RESET];

    always_comb begin
        unique case (paddr)
            `HS_OFF_CTRL, `HS_OFF_MAXSW, `HS_OFF_SWLEN, `HS_OFF_MAXZERO,
            `HS_OFF_STATUS, `HS_OFF_REPORT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // =================================================================
    // configuration registers
    homing_pkg::dist_t maxSwitch_reg;
    homing_pkg::dist_t maxSwitch_next;
    homing_pkg::dist_t switchLen_reg;
    homing_pkg::dist_t switchLen_next;
    homing_pkg::dist_t maxZero_reg;
    homing_pkg::dist_t maxZero_next;
    logic [7:0] channel_reg;
    logic [7:0] channel_next;
    logic [7:0] axisId_reg;
    logic [7:0] axisId_next;

    // ids and limits change only on a completed write
    always_comb begin
        maxSwitch_next = maxSwitch_reg;
        switchLen_next = switchLen_reg;
        maxZero_next = maxZero_reg;
        channel_next = channel_reg;
        axisId_next = axisId_reg;
        if (writeHit) begin
            unique case (paddr)
                `HS_OFF_CTRL: begin
                    channel_next = pwdata[`HS_CTRL_CHAN_LO +: `HS_ID_W];
                    axisId_next = pwdata[`HS_CTRL_AXIS_LO +: `HS_ID_W];
                end
                `HS_OFF_MAXSW: maxSwitch_next = pwdata[`HS_DIST_W-1:0];
                `HS_OFF_SWLEN: switchLen_next = pwdata[`HS_DIST_W-1:0];
                `HS_OFF_MAXZERO: maxZero_next = pwdata[`HS_DIST_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            maxSwitch_reg <= `HS_RST_DIST;
            switchLen_reg <= `HS_RST_DIST;
            maxZero_reg <= `HS_RST_DIST;
            channel_reg <= `HS_RST_ID;
            axisId_reg <= `HS_RST_ID;
        end else if (ce) begin
            maxSwitch_reg <= maxSwitch_next;
            switchLen_reg <= switchLen_next;
            maxZero_reg <= maxZero_next;
            channel_reg <= channel_next;
            axisId_reg <= axisId_next;
        end
    end

    // =================================================================
    // distance accumulators: switch seek / braking, and zero seek
    dist_counter_if swDist ();
    dist_counter_if zeroDist ();

    dist_counter u_sw_dist (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .port(swDist.counter)
    );

    dist_counter u_zero_dist (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .port(zeroDist.counter)
    );

    // =================================================================
    // homing phase machine and error latch
    homing_pkg::phase_e phase_reg;
    homing_pkg::phase_e phase_next;
    logic [15:0] errCode_reg;
    logic [15:0] errCode_next;
    logic [7:0] repChan_reg;
    logic [7:0] repChan_next;
    logic [7:0] repAxis_reg;
    logic [7:0] repAxis_next;
    logic homed_reg;
    logic homed_next;

    always_comb begin
        phase_next = phase_reg;
        errCode_next = errCode_reg;
        repChan_next = repChan_reg;
        repAxis_next = repAxis_reg;
        homed_next = homed_reg;
        unique case (phase_reg)
            homing_pkg::PH_IDLE: begin
                if (startCmd) begin
                    phase_next = homing_pkg::PH_SEEK_SWITCH;
                    homed_next = 1'b0;
                end
            end
            homing_pkg::PH_SEEK_SWITCH: begin
                if (switchRise) begin
                    phase_next = homing_pkg::PH_BRAKE;
                end else if (swDist.over) begin
                    phase_next = homing_pkg::PH_FAULT;
                    errCode_next = `HS_ERR_NO_SWITCH;
                end
            end
            homing_pkg::PH_BRAKE: begin
                // braking past the switch length means the switch is left
                if (!switchOn || swDist.over) begin
                    phase_next = homing_pkg::PH_FAULT;
                    errCode_next = `HS_ERR_SWITCH_LOST;
                end else if (axisStandstill) begin
                    phase_next = homing_pkg::PH_LEAVE;
                end
            end
            homing_pkg::PH_LEAVE: begin
                if (switchFall) begin
                    phase_next = homing_pkg::PH_SEEK_ZERO;
                end
            end
            homing_pkg::PH_SEEK_ZERO: begin
                // the first marker inside the window wins; beyond it none counts
                if (markerRise && !zeroDist.over) begin
                    phase_next = homing_pkg::PH_IDLE;
                    homed_next = 1'b1;
                end else if (zeroDist.over) begin
                    phase_next = homing_pkg::PH_FAULT;
                    errCode_next = `HS_ERR_NO_ZERO;
                end
            end
            homing_pkg::PH_FAULT: begin
                // a fault entered this same cycle is never cleared by it
                if (resetCmd) begin
                    phase_next = homing_pkg::PH_IDLE;
                    errCode_next = `HS_ERR_NONE;
                end
            end
        endcase
        if ((phase_reg != homing_pkg::PH_FAULT) && (phase_next == homing_pkg::PH_FAULT)) begin
            repChan_next = channel_reg;
            repAxis_next = axisId_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            phase_reg <= homing_pkg::PH_IDLE;
            errCode_reg <= `HS_ERR_NONE;
            repChan_reg <= `HS_RST_ID;
            repAxis_reg <= `HS_RST_ID;
            homed_reg <= 1'b0;
        end else if (ce) begin
            phase_reg <= phase_next;
            errCode_reg <= errCode_next;
            repChan_reg <= repChan_next;
            repAxis_reg <= repAxis_next;
            homed_reg <= homed_next;
        end
    end

    // counters clear whenever a new phase is entered
    assign swDist.clear = (phase_next != phase_reg);
    assign zeroDist.clear = (phase_next != phase_reg);
    assign swDist.step = stepPulse &&
        ((phase_reg == homing_pkg::PH_SEEK_SWITCH) || (phase_reg == homing_pkg::PH_BRAKE));
    assign zeroDist.step = stepPulse && (phase_reg == homing_pkg::PH_SEEK_ZERO);
    assign swDist.limit = (phase_reg == homing_pkg::PH_BRAKE) ? switchLen_reg : maxSwitch_reg;
    assign zeroDist.limit = maxZero_reg;

    // =================================================================
    // outputs and bus answer, all registered
    logic startDisable_reg;
    logic startDisable_next;
    logic stopAxis_reg;
    logic stopAxis_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;

    always_comb begin
        startDisable_next = (phase_next == homing_pkg::PH_FAULT);
        stopAxis_next = (phase_next == homing_pkg::PH_FAULT) ||
            (phase_next == homing_pkg::PH_LEAVE && phase_reg == homing_pkg::PH_BRAKE);
        pready_next = psel && !penable;
        pslverr_next = psel && !penable && !mapped;
        prdata_next = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `HS_OFF_CTRL: prdata_next = {8'h00, axisId_reg, channel_reg, 8'h00};
                `HS_OFF_MAXSW: prdata_next = {8'h00, maxSwitch_reg};
                `HS_OFF_SWLEN: prdata_next = {8'h00, switchLen_reg};
                `HS_OFF_MAXZERO: prdata_next = {8'h00, maxZero_reg};
                `HS_OFF_STATUS: prdata_next = {8'h00, swDist.count[15:0] | zeroDist.count[15:0],
                    homed_reg, startDisable_reg, phase_reg};
                `HS_OFF_REPORT: prdata_next = {repAxis_reg, repChan_reg, errCode_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            startDisable_reg <= 1'b0;
            stopAxis_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            startDisable_reg <= startDisable_next;
            stopAxis_reg <= stopAxis_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign startDisable = startDisable_reg;
    assign stopAxis = stopAxis_reg;
    assign homed = homed_reg;
endmodule : homing_supervision

// ==== dv/axis_model.sv ====
// behavioural reference switch and incremental encoder of one axis
`timescale 1ns/10ps
module axis_model (
    input wire logic clock,
    input wire logic rewind,
    input wire logic moving,
    input wire logic [7:0] swAt,
    input wire logic [7:0] swLen,
    input wire logic [7:0] zeroAt,
    output logic travelStep,
    output logic referenceSwitch,
    output logic zeroMarker
);
    // =================================================================
    // position: a step takes four clocks, so each step level lasts two
    logic [9:0] posReg;
    always_ff @(posedge clock) begin
        if (rewind) begin
            posReg <= 10'h000;
        end else if (moving) begin
            posReg <= posReg + 10'h001;
        end
    end
    // the cam is high over swLen steps from swAt; nothing moves while stopped
    assign referenceSwitch = posReg[9:2] >= swAt && posReg[9:2] < swAt + swLen;
    // markers repeat every 32 steps, above any zero limit a homing run sets
    assign zeroMarker = posReg[6:2] == zeroAt[4:0];
    assign travelStep = posReg[1];
endmodule : axis_model

// ==== dv/homing_supervision_sva.sv ====
// assertion checker for the homing supervision block
`timescale 1ns/10ps
`include "homing_params.svh"
module homing_supervision_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic zeroMarker,
    input wire logic startDisable,
    input wire logic stopAxis,
    input wire logic homed
);
    // =================================================================
    // error reset command as seen at the access edge
    logic wrRst;
    assign wrRst = psel && penable && pwrite && paddr == `HS_OFF_CTRL && pwdata[`HS_CTRL_RESET];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // =================================================================
    // properties
    a_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    a_report_code: assert property (pready && !pslverr && !pwrite && paddr == `HS_OFF_REPORT
        && $past(startDisable) |-> prdata[15:0] inside {16'h4e20, 16'h4e21, 16'h4e22})
        else $error("fault report without code");
    a_sd_latch: assert property (startDisable && !wrRst && !$past(wrRst) |=> startDisable)
        else $error("start disable dropped without reset");
    a_sd_release: assert property ($fell(startDisable) |-> $past(wrRst) || $past(wrRst, 2))
        else $error("start disable released without reset");
    a_fault_stops: assert property (startDisable |-> stopAxis)
        else $error("fault without stop");
    a_homed_clean: assert property (homed |-> !startDisable && !stopAxis)
        else $error("homed together with fault");
    a_homed_marker: assert property ($rose(homed) |-> $past(zeroMarker, 2)
        || $past(zeroMarker, 3) || $past(zeroMarker, 4) || $past(zeroMarker, 5))
        else $error("homed without marker");
    a_stop_pulse: assert property (stopAxis && !startDisable |=> !stopAxis)
        else $error("standstill stop longer than a pulse");
    c_homed: cover property ($rose(homed));
    c_fault: cover property ($rose(startDisable));
    c_brake_stop: cover property (stopAxis && !startDisable);
endmodule : homing_supervision_sva

bind homing_supervision homing_supervision_sva sva_i (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zeroMarker(zeroMarker),
    .startDisable(startDisable), .stopAxis(stopAxis), .homed(homed));

// ==== dv/homing_supervision_tb_top.sv ====
// self-checking bench for the homing supervision block
`timescale 1ns/10ps
`include "homing_params.svh"
module homing_supervision_tb_top;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, rerr, moving, rewind;
    logic travelStep, referenceSwitch, zeroMarker, startDisable, stopAxis, homed;
    logic [7:0] paddr, swAt, swLen, zeroAt, chan, axis, sa;
    logic [31:0] pwdata, prdata, rdata, v;
    integer seed, error_cnt, checked;
    // =================================================================
    // clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    homing_supervision DUT (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .referenceSwitch(referenceSwitch),
        .zeroMarker(zeroMarker), .travelStep(travelStep), .axisStandstill(!moving),
        .startDisable(startDisable), .stopAxis(stopAxis), .homed(homed));
    axis_model far_side (.clock(clock), .rewind(rewind), .moving(moving), .swAt(swAt),
        .swLen(swLen), .zeroAt(zeroAt), .travelStep(travelStep),
        .referenceSwitch(referenceSwitch), .zeroMarker(zeroMarker));
    // =================================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one transfer; the idle edge first keeps back-to-back calls race free
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h1, 32'h0);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, exp);
    endtask : rd
    // one homing attempt; the axis halts ten steps into the cam, then moves on
    task automatic run(input logic [7:0] ms, input logic [7:0] ln, input logic [7:0] mz,
        input logic [15:0] code);
        integer n;
        swAt <= sa;
        swLen <= 8'd20;
        zeroAt <= sa + 8'd25;
        rewind <= 1'b1;
        apb(1'b1, `HS_OFF_MAXSW, {24'h0, ms});
        rewind <= 1'b0;
        apb(1'b1, `HS_OFF_SWLEN, {24'h0, ln});
        apb(1'b1, `HS_OFF_MAXZERO, {24'h0, mz});
        apb(1'b1, `HS_OFF_CTRL, {8'h00, axis, chan, 8'h01});
        moving <= 1'b1;
        n = 0;
        while (startDisable !== 1'b1 && homed !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n = n + 1;
            if (n == 4 * sa + 40) moving <= 1'b0;
            if (n == 4 * sa + 48) moving <= 1'b1;
        end
        if (n >= 3000) chk(32'h1, 32'h0);
        // keep travelling so that a later marker passes by
        repeat (60) @(posedge clock);
        moving <= 1'b0;
        chk(homed, code == 16'h0);
        chk(startDisable, code != 16'h0);
        chk(stopAxis, code != 16'h0);
        if (code != 16'h0) begin
            rd(`HS_OFF_REPORT, {axis, chan, code}, 32'hffffffff);
            apb(1'b1, `HS_OFF_CTRL, {8'h00, axis, chan, 8'h01});
            repeat (3) @(posedge clock);
            chk(startDisable, 1'b1);
            apb(1'b1, `HS_OFF_CTRL, {8'h00, axis, chan, 8'h02});
            repeat (3) @(posedge clock);
            chk(startDisable, 1'b0);
            rd(`HS_OFF_STATUS, 32'h01, 32'hff);
            rd(`HS_OFF_REPORT, 32'h0, 32'hffff);
        end
    endtask : run
    task automatic results();
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    // =================================================================
    // main sequence
    initial begin
        seed = 18;
        error_cnt = 0;
        checked = 0;
        rst = 1'b1;
        {psel, penable, pwrite, moving, rewind} = 5'h01;
        paddr = 8'h00;
        pwdata = 32'h0;
        {swAt, swLen, zeroAt} = 24'h081421;
        chan = 8'($random(seed));
        axis = 8'($random(seed));
        sa = 8'd6 + {6'h0, 2'($random(seed))};
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd(`HS_OFF_STATUS, 32'h01, 32'hff);
        rd(`HS_OFF_REPORT, 32'h0, 32'hffffffff);
        apb(1'b0, 8'h18, 32'h0);
        chk(rdata, 32'h0);
        chk(rerr, 1'b1);
        apb(1'b1, `HS_OFF_CTRL, {8'h00, axis, chan, 8'h00});
        rd(`HS_OFF_CTRL, {8'h00, axis, chan, 8'h00}, 32'hffffffff);
        repeat (3) begin
            v = $random(seed) & 32'h00ffffff;
            apb(1'b1, `HS_OFF_MAXZERO, v);
            rd(`HS_OFF_MAXZERO, v, 32'hffffffff);
        end
        run(sa - 8'd3, 8'd20, 8'd20, `HS_ERR_NO_SWITCH);
        run(sa + 8'd2, 8'd3, 8'd20, `HS_ERR_SWITCH_LOST);
        run(sa + 8'd2, 8'd20, 8'd2, `HS_ERR_NO_ZERO);
        // braking length below seek plus braking travel: passes only if the count restarts
        run(sa + 8'd2, 8'd12, 8'd20, `HS_ERR_NONE);
        results();
    end
    // watchdog far beyond the several hundred cycles the sequence needs
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        results();
    end
endmodule : homing_supervision_tb_top
